// ### rtl/rgmd_pkg.sv
// Package for the regulator mode decoder: mode codes, carriers, timing.
// Assumes a single 250 MHz clock domain.
package rgmd_pkg;

   localparam int NUM_LDO_DEF  = 10;
   localparam int NUM_CONV_DEF = 4;
   localparam int NUM_PIN_DEF  = 4;

   // Sleep sequencing: three slots, fixed spacing
   localparam int  CLK_PERIOD_PS    = 4000;
   localparam int  SLOT_GAP_US      = 120;
   localparam int  SLOT_GAP_CYCLES  = (SLOT_GAP_US * 1000000) / CLK_PERIOD_PS;
   localparam int  SEQ_SLOT_COUNT   = 3;

   // Device states seen by the decoder
   typedef enum logic [1:0] {
      RGMD_DEV_OTHER  = 2'h0,
      RGMD_DEV_ACTIVE = 2'h1,
      RGMD_DEV_SLEEP  = 2'h2
   } rgmd_dev_state_t;

   // Resource modes
   typedef enum logic [2:0] {
      RGMD_MODE_OFF    = 3'h0,
      RGMD_MODE_NORMAL = 3'h1,
      RGMD_MODE_LOWQ   = 3'h2,
      RGMD_MODE_AUTO   = 3'h3,
      RGMD_MODE_PWM    = 3'h4
   } rgmd_mode_t;

   // Per-regulator control bits
   typedef struct packed {
      logic master_on;
      logic hold_on;
      logic shutdown_in_low;
      logic low_quiescent;
      logic converter_forced_pwm;
   } rgmd_ctrl_t;

   // Sequencer states
   typedef enum logic [1:0] {
      RGMD_SEQ_IDLE = 2'h0,
      RGMD_SEQ_WAIT = 2'h1
   } rgmd_seq_state_t;

endpackage : rgmd_pkg

// ### rtl/rgmd_decode.sv
// One regulator's combinational mode decode.
// Assumes inputs are already synchronised to the block clock.
`timescale 1ns/10ps
`default_nettype none
module rgmd_decode
   import rgmd_pkg::*;
#(
   parameter bit IS_CONVERTER = 1'b0
)
(
   // Controls
   input  wire rgmd_ctrl_t      i_ctrl,
   input  wire logic            i_assigned,
   input  wire logic            i_pin_high,
   input  wire logic            i_strap_always_on,
   input  wire rgmd_dev_state_t i_dev_state,
   // Result
   output rgmd_mode_t           o_mode
);

   wire logic pins_live  = (i_dev_state == RGMD_DEV_ACTIVE) || (i_dev_state == RGMD_DEV_SLEEP);
   wire logic is_asleep  = i_strap_always_on && (i_dev_state == RGMD_DEV_SLEEP);
   // pins count only in active or sleep
   wire logic pin_eff    = i_pin_high && pins_live;
   wire logic pwm        = IS_CONVERTER && i_ctrl.converter_forced_pwm;
   // converters add auto or forced PWM
   wire rgmd_mode_t on_mode = IS_CONVERTER ? (pwm ? RGMD_MODE_PWM : RGMD_MODE_AUTO)
                                           : RGMD_MODE_NORMAL;
   wire rgmd_mode_t run_mode = i_ctrl.low_quiescent && !pwm ? RGMD_MODE_LOWQ : on_mode;
   wire rgmd_mode_t low_mode = pwm ? RGMD_MODE_PWM : RGMD_MODE_LOWQ;
   wire rgmd_mode_t drop_mode = i_ctrl.shutdown_in_low ? RGMD_MODE_OFF : low_mode;

   wire rgmd_mode_t asg_mode = (pin_eff || i_ctrl.hold_on) ? on_mode : drop_mode;
   wire rgmd_mode_t una_mode = (!is_asleep || i_ctrl.hold_on) ? run_mode : drop_mode;

   // master bit forces off in every case
   assign o_mode = !i_ctrl.master_on ? RGMD_MODE_OFF : (i_assigned ? asg_mode : una_mode);

endmodule // rgmd_decode
`default_nettype wire

// ### rtl/rgmd_top.sv
// Regulator mode decoder: per-regulator mode and sleep slot pacing.
// Assumes pins and strap are asynchronous; control bits come from the same clock.
`timescale 1ns/10ps
`default_nettype none
module rgmd_top
   import rgmd_pkg::*;
#(
   parameter int NUM_LDO  = NUM_LDO_DEF,
   parameter int NUM_CONV = NUM_CONV_DEF,
   parameter int NUM_PIN  = NUM_PIN_DEF,
   parameter int NUM_REG  = NUM_LDO + NUM_CONV
)
(
   // Clock and reset
   input  wire logic                         i_clk,
   input  wire logic                         i_reset_n,
   // Per-regulator controls, LDOs first then converters
   input  wire rgmd_ctrl_t [NUM_REG-1:0]     i_ctrl,
   // Pin assignment map: one regulator mask per pin
   input  wire logic [NUM_PIN-1:0][NUM_REG-1:0] i_pin_assignment_map,
   // Asynchronous pins
   input  wire logic [NUM_PIN-1:0]           i_external_enable_pin,
   input  wire logic                         i_pin_role_strap,
   // Device state and sequencing request
   input  wire rgmd_dev_state_t              i_dev_state,
   input  wire logic                         i_seq_start,
   // Results
   output rgmd_mode_t [NUM_REG-1:0]          o_mode,
   output logic [1:0]                        o_seq_slot,
   output logic                              o_seq_slot_pulse,
   output logic                              o_seq_busy
);

   // Elaboration checks on counts and counter widths
   generate
      if (NUM_LDO < 1 || NUM_CONV < 1 || NUM_PIN < 1)
      begin : g_bad_count
         $error("rgmd_top: regulator and pin counts must be at least one");
      end
      if (NUM_REG != NUM_LDO + NUM_CONV)
      begin : g_bad_total
         $error("rgmd_top: regulator total must be LDO count plus converter count");
      end
      if (SLOT_GAP_CYCLES < 1 || SLOT_GAP_CYCLES > 65536)
      begin : g_bad_gap
         $error("rgmd_top: slot gap does not fit the 16-bit gap counter");
      end
      if (SEQ_SLOT_COUNT < 1 || SEQ_SLOT_COUNT > 4)
      begin : g_bad_slots
         $error("rgmd_top: slot count does not fit the 2-bit slot register");
      end
   endgenerate

   // Two-flop synchronisers for pins and strap
   logic [NUM_PIN-1:0] pin_meta;
   logic [NUM_PIN-1:0] pin_sync;
   logic               strap_meta;
   logic               strap_sync;

   // Enable pin synchroniser
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= i_external_enable_pin;
         pin_sync <= pin_meta;
      end
   end

   // Strap synchroniser
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end
      else
      begin
         strap_meta <= i_pin_role_strap;
         strap_sync <= strap_meta;
      end
   end

   rgmd_mode_t [NUM_REG-1:0] next_mode;

   genvar g;
   generate
      for (g = 0; g < NUM_REG; g++)
      begin : g_reg
         logic [NUM_PIN-1:0] sel;
         for (genvar p = 0; p < NUM_PIN; p++)
         begin : g_pin
            assign sel[p] = i_pin_assignment_map[p][g];
         end
         wire logic assigned = |sel;
         wire logic pin_high = |(sel & pin_sync);

         // Converters follow the LDOs
         localparam bit IS_CONV = (g >= NUM_LDO);

         rgmd_decode #(
            .IS_CONVERTER (IS_CONV)
         ) u_decode (
            .i_ctrl            (i_ctrl[g]),
            .i_assigned        (assigned),
            .i_pin_high        (pin_high),
            .i_strap_always_on (strap_sync),
            .i_dev_state       (i_dev_state),
            .o_mode            (next_mode[g])
         );
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_mode <= '{default: RGMD_MODE_OFF};
      else
         o_mode <= next_mode;
   end

   // Sleep sequencing slot pacing
   localparam logic [15:0] GAP_LAST = 16'(SLOT_GAP_CYCLES - 1);
   localparam logic [1:0]  SLOT_LAST = 2'(SEQ_SLOT_COUNT - 1);

   rgmd_seq_state_t seq_state;
   logic [15:0]     gap_cnt;

   // Sequencer next values
   rgmd_seq_state_t next_seq_state;
   logic [15:0]     next_gap_cnt;
   logic [1:0]      next_seq_slot;
   logic            next_seq_slot_pulse;
   logic            next_seq_busy;

   wire logic gap_done = (gap_cnt == GAP_LAST);
   wire logic last_slot = (o_seq_slot == SLOT_LAST);

   // three slots spaced by fixed delay
   always_comb
   begin
      next_seq_state      = seq_state;
      next_gap_cnt        = gap_cnt;
      next_seq_slot       = o_seq_slot;
      next_seq_slot_pulse = 1'b0;
      next_seq_busy       = o_seq_busy;
      unique case (seq_state)
         RGMD_SEQ_IDLE:
         begin
            if (i_seq_start)
            begin
               next_seq_state      = RGMD_SEQ_WAIT;
               next_seq_slot       = 2'h0;
               next_seq_slot_pulse = 1'b1;
               next_seq_busy       = 1'b1;
               next_gap_cnt        = 16'h0000;
            end
         end
         RGMD_SEQ_WAIT:
         begin
            if (last_slot)
            begin
               next_seq_state = RGMD_SEQ_IDLE;
               next_seq_busy  = 1'b0;
            end
            else if (gap_done)
            begin
               next_gap_cnt        = 16'h0000;
               next_seq_slot       = o_seq_slot + 2'h1;
               next_seq_slot_pulse = 1'b1;
            end
            else
               next_gap_cnt = gap_cnt + 16'h0001;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         seq_state        <= RGMD_SEQ_IDLE;
         gap_cnt          <= 16'h0000;
         o_seq_slot       <= 2'h0;
         o_seq_slot_pulse <= 1'b0;
         o_seq_busy       <= 1'b0;
      end
      else
      begin
         seq_state        <= next_seq_state;
         gap_cnt          <= next_gap_cnt;
         o_seq_slot       <= next_seq_slot;
         o_seq_slot_pulse <= next_seq_slot_pulse;
         o_seq_busy       <= next_seq_busy;
      end
   end

endmodule // rgmd_top
`default_nettype wire

// ### verif/rgmd_checker.sv
// Checker for the regulator mode decoder, bound to the top module.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module rgmd_checker
   import rgmd_pkg::*;
#(
   parameter int NUM_LDO  = NUM_LDO_DEF,
   parameter int NUM_CONV = NUM_CONV_DEF,
   parameter int NUM_PIN  = NUM_PIN_DEF,
   parameter int NUM_REG  = NUM_LDO + NUM_CONV
)
(
   // Clock and reset
   input wire logic                            i_clk,
   input wire logic                            i_reset_n,
   // Inputs
   input wire rgmd_ctrl_t [NUM_REG-1:0]        i_ctrl,
   input wire logic [NUM_PIN-1:0][NUM_REG-1:0] i_pin_assignment_map,
   input wire logic [NUM_PIN-1:0]              i_external_enable_pin,
   input wire logic                            i_pin_role_strap,
   input wire rgmd_dev_state_t                 i_dev_state,
   input wire logic                            i_seq_start,
   // Outputs
   input wire rgmd_mode_t [NUM_REG-1:0]        o_mode,
   input wire logic [1:0]                      o_seq_slot,
   input wire logic                            o_seq_slot_pulse,
   input wire logic                            o_seq_busy
);
   logic [15:0] gap;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Cycles since last slot pulse
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         gap <= 16'h0;
      else if (o_seq_slot_pulse)
         gap <= 16'h1;
      else if (gap != 16'hFFFF)
         gap <= gap + 16'h1;
   end
   master_off_a: assert property (!i_ctrl[0].master_on |=> o_mode[0] == RGMD_MODE_OFF)
      else $error("mode not off with master bit clear");
   ldo_three_a: assert property (o_mode[NUM_LDO-1] inside
      {RGMD_MODE_OFF, RGMD_MODE_NORMAL, RGMD_MODE_LOWQ})
      else $error("ldo mode outside its three modes");
   conv_states_a: assert property (o_mode[NUM_REG-1] != RGMD_MODE_NORMAL)
      else $error("converter in normal mode");
   start_reply_a: assert property (i_seq_start && !o_seq_busy |=>
      o_seq_slot_pulse && o_seq_busy && o_seq_slot == 2'h0)
      else $error("start not answered with slot 0");
   pulse_single_a: assert property (o_seq_slot_pulse |=> !o_seq_slot_pulse)
      else $error("slot pulse longer than one cycle");
   slot_gap_a: assert property (o_seq_slot_pulse && o_seq_slot != 2'h0 |->
      gap == SLOT_GAP_CYCLES) else $error("slot spacing wrong");
   slot_change_a: assert property (!$stable(o_seq_slot) |-> o_seq_slot_pulse)
      else $error("slot changed without pulse");
   busy_end_a: assert property (o_seq_slot_pulse && o_seq_slot == 2'h2 |=> !o_seq_busy)
      else $error("busy held after third slot");
   seq_end_c: cover property (o_seq_slot_pulse && o_seq_slot == 2'h2);
   conv_pwm_c: cover property (o_mode[NUM_REG-1] == RGMD_MODE_PWM);
   ldo_lowq_c: cover property (o_mode[0] == RGMD_MODE_LOWQ);
endmodule // rgmd_checker
bind rgmd_top rgmd_checker #(.NUM_LDO(NUM_LDO), .NUM_CONV(NUM_CONV), .NUM_PIN(NUM_PIN),
   .NUM_REG(NUM_REG)) chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ctrl(i_ctrl),
   .i_pin_assignment_map(i_pin_assignment_map), .i_external_enable_pin(i_external_enable_pin),
   .i_pin_role_strap(i_pin_role_strap), .i_dev_state(i_dev_state), .i_seq_start(i_seq_start),
   .o_mode(o_mode), .o_seq_slot(o_seq_slot), .o_seq_slot_pulse(o_seq_slot_pulse),
   .o_seq_busy(o_seq_busy));
`default_nettype wire

// ### verif/rgmd_top_tb.sv
// Testbench for the regulator mode decoder: mode table rows and one sequence.
// Assumes two LDOs, two converters and two pins.
`timescale 1ns/10ps
`default_nettype none
module rgmd_top_tb
   import rgmd_pkg::*;
;
   logic                  clk, rst_n, strap, start, pulse, busy;
   rgmd_ctrl_t [3:0]      ctrl;
   logic [1:0][3:0]       map;
   logic [1:0]            pin, slot;
   rgmd_dev_state_t       st;
   rgmd_mode_t [3:0]      mode;
   int                    mismatches, tests_run, n, k;
   rgmd_top #(.NUM_LDO(2), .NUM_CONV(2), .NUM_PIN(2)) DUT (.i_clk(clk), .i_reset_n(rst_n),
      .i_ctrl(ctrl), .i_pin_assignment_map(map), .i_external_enable_pin(pin),
      .i_pin_role_strap(strap), .i_dev_state(st), .i_seq_start(start), .o_mode(mode),
      .o_seq_slot(slot), .o_seq_slot_pulse(pulse), .o_seq_busy(busy));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // Map rows and pin levels per call, mode checked after the synchroniser delay
   task tm(input int r, input logic [4:0] c, input logic [1:0] a, input logic [1:0] p,
      input logic s, input logic [1:0] d, input logic [2:0] e);
      @(posedge clk);
      ctrl[r] <= rgmd_ctrl_t'(c);
      map[0][r] <= a[0];
      map[1][r] <= a[1];
      pin <= p;
      strap <= s;
      st <= rgmd_dev_state_t'(d);
      repeat (5) @(posedge clk);
      #1 chk("o_mode", 16'(e), 16'(mode[r]));
   endtask
   // Pin 1 drives, both map rows carry the same assignment bit a
   task t(input int r, input logic [4:0] c, input logic a, input logic p,
      input logic s, input logic [1:0] d, input logic [2:0] e);
      tm(r, c, {a, a}, {p, 1'h0}, s, d, e);
   endtask
   task automatic complete_run();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      #300000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      rst_n = 1'h0;
      strap = 1'h0;
      start = 1'h0;
      ctrl  = '0;
      map   = '0;
      pin   = 2'h0;
      st    = RGMD_DEV_OTHER;
      n = 0;
      k = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      t(0, 5'h08, 1, 1, 0, 1, 3'h0);
      t(0, 5'h10, 1, 1, 0, 1, 3'h1);
      t(0, 5'h18, 1, 0, 0, 1, 3'h1);
      t(0, 5'h14, 1, 0, 0, 1, 3'h0);
      t(0, 5'h10, 1, 0, 0, 1, 3'h2);
      t(0, 5'h10, 1, 1, 0, 0, 3'h2);
      tm(0, 5'h10, 2'h1, 2'h2, 0, 1, 3'h2);
      tm(0, 5'h10, 2'h1, 2'h1, 0, 1, 3'h1);
      tm(0, 5'h10, 2'h3, 2'h2, 0, 1, 3'h1);
      t(1, 5'h12, 0, 0, 0, 2, 3'h2);
      t(1, 5'h10, 0, 0, 1, 1, 3'h1);
      t(1, 5'h14, 0, 0, 1, 2, 3'h0);
      t(1, 5'h1A, 0, 0, 1, 2, 3'h2);
      t(1, 5'h10, 0, 0, 1, 2, 3'h2);
      t(1, 5'h18, 0, 0, 1, 2, 3'h1);
      t(2, 5'h11, 1, 1, 0, 1, 3'h4);
      t(2, 5'h10, 1, 1, 0, 1, 3'h3);
      t(2, 5'h15, 1, 0, 0, 1, 3'h0);
      t(2, 5'h11, 1, 0, 0, 1, 3'h4);
      t(2, 5'h18, 1, 0, 0, 1, 3'h3);
      t(2, 5'h10, 1, 0, 0, 1, 3'h2);
      t(2, 5'h19, 1, 0, 0, 1, 3'h4);
      t(3, 5'h13, 0, 0, 0, 1, 3'h4);
      t(3, 5'h12, 0, 0, 0, 1, 3'h2);
      t(3, 5'h10, 0, 0, 0, 1, 3'h3);
      t(3, 5'h1A, 0, 0, 1, 2, 3'h2);
      t(3, 5'h14, 0, 0, 1, 2, 3'h0);
      t(3, 5'h11, 0, 0, 1, 2, 3'h4);
      t(3, 5'h19, 0, 0, 1, 2, 3'h4);
      @(posedge clk);
      start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      #1;
      while (busy === 1'h1 && n < 70000)
      begin
         n++;
         k += int'(pulse);
         @(posedge clk);
         start <= (n == 5);
         #1;
      end
      chk("busy cycles", 16'(2 * SLOT_GAP_CYCLES + 1), 16'(n));
      chk("slot pulses", 16'(SEQ_SLOT_COUNT), 16'(k));
      chk("o_seq_slot", 16'h0002, 16'(slot));
      // Mid-run reset clears outputs, modes return after release
      @(posedge clk);
      rst_n <= 1'h0;
      @(posedge clk);
      #1 chk("o_mode all", 16'h0000, 16'(mode));
      chk("o_seq_busy", 16'h0000, 16'(busy));
      @(posedge clk);
      rst_n <= 1'h1;
      repeat (5) @(posedge clk);
      #1 chk("o_mode", 16'(RGMD_MODE_PWM), 16'(mode[3]));
      complete_run();
   end
endmodule // rgmd_top_tb
`default_nettype wire
